// ==== rtl/fqs_pkg.sv ====
package fqs_pkg;
  // Flash pin widths
  localparam int FQS_AW = 22;
  localparam int FQS_DW = 16;
  // Clock period and strobe timing (plain defaults)
  localparam int CLK_NS = 4;
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 120;
  localparam int T_HOLD_NS = 40;
  // Least times round up to whole cycles
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  // Own register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_WDATA = 5'h08;
  localparam logic [4:0] OFS_RDATA = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [4:0] OFS_OPC_A = 5'h14;
  localparam logic [4:0] OFS_OPC_B = 5'h18;
  // Reset values
  localparam logic [31:0] OPC_RST = 32'h0000_0000;
  // Device status byte bit positions
  localparam int SB_READY = 7;
  localparam int SB_ERASE_FAIL = 5;
  localparam int SB_PROG_FAIL = 4;
  localparam int SB_SUPPLY_LOCK = 3;
  localparam int SB_LOCK_PROT = 1;
  // Word index of the identifier codes
  localparam logic [FQS_AW-1:0] ID_MAKER_IDX = 22'h00_0000;
  localparam logic [FQS_AW-1:0] ID_PART_IDX = 22'h00_0001;
  localparam logic [FQS_AW-1:0] ID_BLOCK_IDX = 22'h00_0002;
  // Operations software can start
  typedef enum logic [2:0] {
    OP_WRITE, OP_READ, OP_ERASE, OP_RD_STATUS, OP_CLR_STATUS, OP_ID_READ, OP_BUF_STATUS
  } fqs_op_t;
  // Pins driven toward the flash
  typedef struct packed {
    logic [FQS_AW-1:0] addr;
    logic chip_select_a_n;
    logic chip_select_b_n;
    logic oe_n;
    logic we_n;
    logic [FQS_DW-1:0] dq_out;
    logic dq_oe_n;
  } fqs_pins_t;
  // One step of an operation
  typedef struct packed {
    logic wr;
    logic last;
    logic poll;
    logic [7:0] opcode;
    logic use_opcode;
  } fqs_step_t;
endpackage : fqs_pkg

// ==== rtl/fqs_cycle.sv ====
`timescale 1ns/1ps
// One asynchronous bus cycle: setup, strobe pulse, hold with strobes high
module fqs_cycle (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_wr,
  input wire logic [fqs_pkg::FQS_AW-1:0] i_addr,
  input wire logic [fqs_pkg::FQS_DW-1:0] i_wdata,
  input wire logic [fqs_pkg::FQS_DW-1:0] i_dq,
  output logic o_busy,
  output logic o_done,
  output logic [fqs_pkg::FQS_DW-1:0] o_rdata,
  output fqs_pkg::fqs_pins_t o_pins
);
  typedef enum {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} fqs_cy_t;
  fqs_cy_t st_reg; // Cycle phase
  logic [7:0] cnt_reg; // Cycles left in phase
  logic wr_reg; // Current cycle is a write

  assign o_busy = (st_reg != CY_IDLE);

  // Phase sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st_reg <= CY_IDLE;
      cnt_reg <= 8'h00;
      wr_reg <= 1'b0;
    end else if (i_ce) begin
      case (st_reg)
        CY_IDLE: begin
          if (i_start) begin
            st_reg <= CY_SETUP;
            cnt_reg <= fqs_pkg::SETUP_CYC;
            wr_reg <= i_wr;
          end
        end
        CY_SETUP: begin
          if (cnt_reg <= 8'h01) begin
            st_reg <= CY_PULSE;
            cnt_reg <= fqs_pkg::PULSE_CYC;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        CY_PULSE: begin
          if (cnt_reg <= 8'h01) begin
            st_reg <= CY_HOLD;
            cnt_reg <= fqs_pkg::HOLD_CYC;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        CY_HOLD: begin
          // Strobes stay high here so the next read takes a fresh snapshot
          if (cnt_reg <= 8'h01) begin
            st_reg <= CY_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: st_reg <= CY_IDLE;
      endcase
    end
  end

  // Done pulse as the hold phase ends
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= (st_reg == CY_HOLD) && (cnt_reg <= 8'h01);
    end
  end

  // Read data sampled on the last pulse cycle, before the strobe rises
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rdata <= '0;
    end else if (i_ce && st_reg == CY_PULSE && cnt_reg <= 8'h01 && !wr_reg) begin
      o_rdata <= i_dq;
    end
  end

  // Pin drive; selects low from setup to end of pulse
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pins <= '{addr: '0, chip_select_a_n: 1'b1, chip_select_b_n: 1'b1,
                  oe_n: 1'b1, we_n: 1'b1, dq_out: '0, dq_oe_n: 1'b1};
    end else if (i_ce) begin
      case (st_reg)
        CY_IDLE: begin
          if (i_start) begin
            o_pins.addr <= i_addr;
            o_pins.dq_out <= i_wdata;
            o_pins.dq_oe_n <= !i_wr;
            o_pins.chip_select_a_n <= 1'b0;
            o_pins.chip_select_b_n <= 1'b0;
          end
        end
        CY_SETUP: begin
          if (cnt_reg <= 8'h01) begin
            o_pins.we_n <= !wr_reg;
            o_pins.oe_n <= wr_reg;
          end
        end
        CY_PULSE: begin
          if (cnt_reg <= 8'h01) begin
            o_pins.we_n <= 1'b1;
            o_pins.oe_n <= 1'b1;
            o_pins.chip_select_a_n <= 1'b1;
            o_pins.chip_select_b_n <= 1'b1;
          end
        end
        CY_HOLD: begin
          if (cnt_reg <= 8'h01) begin
            o_pins.dq_oe_n <= 1'b1;
          end
        end
        default: o_pins.dq_oe_n <= 1'b1;
      endcase
    end
  end
endmodule : fqs_cycle

// ==== rtl/fqs_host.sv ====
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - Identifier mode holds until next command
// - Status latched on late falling strobe
// - Host reissues buffer setup to refresh
// - Erase is setup then confirm, same block
module fqs_host (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // AXI4-Lite slave
  input wire logic [4:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [4:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Flash pins
  input wire logic [fqs_pkg::FQS_DW-1:0] i_dq,
  output fqs_pkg::fqs_pins_t o_flash
);
  // Merge a write into a register under its byte strobes
  function automatic logic [31:0] fqs_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : fqs_merge

  // Collect the four failure bits of a status byte
  function automatic logic [3:0] fqs_fails(input logic [7:0] sb);
    return {sb[fqs_pkg::SB_ERASE_FAIL], sb[fqs_pkg::SB_PROG_FAIL],
            sb[fqs_pkg::SB_SUPPLY_LOCK], sb[fqs_pkg::SB_LOCK_PROT]};
  endfunction : fqs_fails

  // Software registers
  logic [3:0] op_cfg_reg; // Op code field written to CTRL
  logic [fqs_pkg::FQS_AW-1:0] addr_reg; // Flash address or identifier word index
  logic [fqs_pkg::FQS_DW-1:0] wdata_reg; // Data for raw write
  logic [31:0] opc_a_reg; // Setup, confirm, read-status, clear-status opcodes
  logic [15:0] opc_b_reg; // Identifier and buffer-setup opcodes
  logic [fqs_pkg::FQS_DW-1:0] res_reg; // Last read data
  logic done_reg; // Sticky completion flag
  logic [3:0] fail_reg; // Sticky failure bits from last polled status
  // AXI write side
  logic aw_got_reg;
  logic w_got_reg;
  logic [4:0] waddr_reg;
  logic [31:0] wd_reg;
  logic [3:0] ws_reg;
  logic wr_fire; // Both halves held: perform the write
  logic go; // Start strobe from CTRL write
  logic [31:0] addr_mrg, wdat_mrg, opcb_mrg; // Byte-merged words, sliced at the write
  // Engine
  typedef enum {EN_IDLE, EN_RUN, EN_WAIT} fqs_en_t;
  fqs_en_t en_reg;
  fqs_pkg::fqs_op_t op_reg; // Operation in progress
  logic [1:0] step_reg; // Step within operation
  fqs_pkg::fqs_step_t stp; // Current step descriptor
  logic [fqs_pkg::FQS_AW-1:0] cyc_addr;
  logic [fqs_pkg::FQS_DW-1:0] cyc_data;
  logic cyc_busy;
  logic cyc_done;
  logic [fqs_pkg::FQS_DW-1:0] cyc_rdata;

  // AXI handshake: one write and one read at a time
  assign o_awready = !aw_got_reg && !o_bvalid;
  assign o_wready = !w_got_reg && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign wr_fire = aw_got_reg && w_got_reg;
  assign go = wr_fire && waddr_reg == fqs_pkg::OFS_CTRL && ws_reg[0] && wd_reg[0];
  // Merges kept as full words so each register takes only its own width
  assign addr_mrg = fqs_merge(32'(addr_reg), wd_reg, ws_reg);
  assign wdat_mrg = fqs_merge(32'(wdata_reg), wd_reg, ws_reg);
  assign opcb_mrg = fqs_merge(32'(opc_b_reg), wd_reg, ws_reg);

  // Capture write address and data in either order
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
    end else if (i_ce) begin
      if (i_awvalid && o_awready) begin
        aw_got_reg <= 1'b1;
        waddr_reg <= i_awaddr;
      end else if (wr_fire) begin
        aw_got_reg <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_got_reg <= 1'b1;
        wd_reg <= i_wdata;
        ws_reg <= i_wstrb;
      end else if (wr_fire) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end else if (i_ce) begin
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        case (waddr_reg)
          fqs_pkg::OFS_CTRL, fqs_pkg::OFS_ADDR, fqs_pkg::OFS_WDATA, fqs_pkg::OFS_STAT,
          fqs_pkg::OFS_OPC_A, fqs_pkg::OFS_OPC_B: o_bresp <= 2'h0;
          default: o_bresp <= 2'h2;
        endcase
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; writes while busy still land, and address, data and opcodes feed the remaining steps of the op in progress
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      op_cfg_reg <= 4'h0;
      addr_reg <= '0;
      wdata_reg <= '0;
      opc_a_reg <= fqs_pkg::OPC_RST;
      opc_b_reg <= fqs_pkg::OPC_RST[15:0];
    end else if (i_ce && wr_fire) begin
      case (waddr_reg)
        fqs_pkg::OFS_CTRL: if (ws_reg[0]) op_cfg_reg <= wd_reg[4:1];
        fqs_pkg::OFS_ADDR: addr_reg <= addr_mrg[fqs_pkg::FQS_AW-1:0];
        fqs_pkg::OFS_WDATA: wdata_reg <= wdat_mrg[fqs_pkg::FQS_DW-1:0];
        fqs_pkg::OFS_OPC_A: opc_a_reg <= fqs_merge(opc_a_reg, wd_reg, ws_reg);
        fqs_pkg::OFS_OPC_B: opc_b_reg <= opcb_mrg[15:0];
        default: ;
      endcase
    end
  end

  // Register read port
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
    end else if (i_ce) begin
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= 2'h0;
        case (i_araddr)
          fqs_pkg::OFS_CTRL: o_rdata <= {27'h0, op_cfg_reg, 1'b0};
          fqs_pkg::OFS_ADDR: o_rdata <= 32'(addr_reg);
          fqs_pkg::OFS_WDATA: o_rdata <= 32'(wdata_reg);
          fqs_pkg::OFS_RDATA: o_rdata <= 32'(res_reg);
          fqs_pkg::OFS_STAT: o_rdata <= {26'h0, fail_reg, done_reg, en_reg != EN_IDLE};
          fqs_pkg::OFS_OPC_A: o_rdata <= opc_a_reg;
          fqs_pkg::OFS_OPC_B: o_rdata <= {16'h0, opc_b_reg};
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'h2;
          end
        endcase
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Step table: every op that changes device read mode opens with its command write
  always_comb begin
    stp = '{wr: 1'b0, last: 1'b1, poll: 1'b0, opcode: 8'h00, use_opcode: 1'b0};
    case (op_reg)
      fqs_pkg::OP_WRITE: stp.wr = 1'b1;
      fqs_pkg::OP_READ: ;
      fqs_pkg::OP_ERASE: begin
        // Setup then confirm at the same in-block address, then poll
        case (step_reg)
          2'h0: stp = '{1'b1, 1'b0, 1'b0, opc_a_reg[7:0], 1'b1};
          2'h1: stp = '{1'b1, 1'b0, 1'b0, opc_a_reg[15:8], 1'b1};
          default: stp.poll = 1'b1;
        endcase
      end
      fqs_pkg::OP_RD_STATUS: begin
        if (step_reg == 2'h0) stp = '{1'b1, 1'b0, 1'b0, opc_a_reg[23:16], 1'b1};
      end
      fqs_pkg::OP_CLR_STATUS: stp = '{1'b1, 1'b1, 1'b0, opc_a_reg[31:24], 1'b1};
      fqs_pkg::OP_ID_READ: begin
        if (step_reg == 2'h0) stp = '{1'b1, 1'b0, 1'b0, opc_b_reg[7:0], 1'b1};
      end
      fqs_pkg::OP_BUF_STATUS: begin
        // Setup is reissued on every request so the snapshot is fresh
        if (step_reg == 2'h0) stp = '{1'b1, 1'b0, 1'b0, opc_b_reg[15:8], 1'b1};
      end
      default: ;
    endcase
  end

  // Identifier reads use the word index from line one upward
  assign cyc_addr = (op_reg == fqs_pkg::OP_ID_READ && !stp.wr) ?
                    {addr_reg[fqs_pkg::FQS_AW-2:0], 1'b0} : addr_reg;
  assign cyc_data = stp.use_opcode ? {8'h00, stp.opcode} : wdata_reg;

  // Operation sequencer
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      en_reg <= EN_IDLE;
      op_reg <= fqs_pkg::OP_WRITE;
      step_reg <= 2'h0;
    end else if (i_ce) begin
      case (en_reg)
        EN_IDLE: begin
          if (go) begin
            op_reg <= fqs_pkg::fqs_op_t'(wd_reg[3:1]); // Op rides in the same write as go
            step_reg <= 2'h0;
            en_reg <= EN_RUN;
          end
        end
        EN_RUN: if (!cyc_busy) en_reg <= EN_WAIT;
        EN_WAIT: begin
          if (cyc_done) begin
            if (stp.poll && !cyc_rdata[fqs_pkg::SB_READY]) begin
              en_reg <= EN_RUN;
            end else if (stp.last) begin
              en_reg <= EN_IDLE;
            end else begin
              step_reg <= step_reg + 2'h1;
              en_reg <= EN_RUN;
            end
          end
        end
        default: en_reg <= EN_IDLE;
      endcase
    end
  end

  // Results; completion beats a same-cycle clear of the done flag
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      res_reg <= '0;
      done_reg <= 1'b0;
      fail_reg <= 4'h0;
    end else if (i_ce) begin
      if (en_reg == EN_WAIT && cyc_done && !stp.wr) res_reg <= cyc_rdata;
      // Failure bits only trusted once the ready bit is seen set
      if (en_reg == EN_WAIT && cyc_done && stp.poll && cyc_rdata[fqs_pkg::SB_READY]) begin
        fail_reg <= fqs_fails(cyc_rdata[7:0]);
      end else if (wr_fire && waddr_reg == fqs_pkg::OFS_STAT && ws_reg[0] && wd_reg[2]) begin
        fail_reg <= 4'h0;
      end
      if (en_reg == EN_WAIT && cyc_done && stp.last && !(stp.poll && !cyc_rdata[7])) begin
        done_reg <= 1'b1;
      end else if (wr_fire && waddr_reg == fqs_pkg::OFS_STAT && ws_reg[0] && wd_reg[1]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // Bus cycle engine
  fqs_cycle u_cycle (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_start(en_reg == EN_RUN),
    .i_wr(stp.wr),
    .i_addr(cyc_addr),
    .i_wdata(cyc_data),
    .i_dq(i_dq),
    .o_busy(cyc_busy),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_pins(o_flash)
  );
endmodule : fqs_host

// ==== test/fqs_host_assertions.sv ====
`timescale 1ns/1ps
// Watches the software bus handshakes and the flash strobe timing
module fqs_host_assertions (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire fqs_pkg::fqs_pins_t o_flash
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Cycles the present strobe has been low; a frozen clock enable must not count
  logic [7:0] low_cnt;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) low_cnt <= 8'h00;
    else if (o_flash.oe_n && o_flash.we_n) low_cnt <= 8'h00;
    else if (i_ce) low_cnt <= low_cnt + 8'h01;
  end
  property p_pulse;
    ($rose(o_flash.oe_n) || $rose(o_flash.we_n)) |-> low_cnt == fqs_pkg::PULSE_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe pulse length wrong");
  property p_setup;
    $fell(o_flash.chip_select_a_n) |-> (o_flash.oe_n && o_flash.we_n) [*5];
  endproperty
  a_setup: assert property (p_setup) else $error("strobe fell inside setup");
  property p_sel_pair;
    o_flash.chip_select_a_n == o_flash.chip_select_b_n;
  endproperty
  a_sel_pair: assert property (p_sel_pair) else $error("selects split");
  property p_one_strobe;
    o_flash.oe_n || o_flash.we_n;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_wr_drive;
    !o_flash.we_n |-> !o_flash.dq_oe_n && $stable(o_flash.dq_out);
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not held");
  property p_rd_float;
    !o_flash.oe_n |-> o_flash.dq_oe_n;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("host drives during read");
  property p_addr_hold;
    !o_flash.chip_select_a_n && !$past(o_flash.chip_select_a_n) |-> $stable(o_flash.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar;
    o_arready == !o_rvalid;
  endproperty
  a_ar: assert property (p_ar) else $error("arready wrong");
  property p_b_time;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write answer late");
  property p_r_time;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  c_wr: cover property ($fell(o_flash.we_n));
  c_rd: cover property ($fell(o_flash.oe_n));
  c_err: cover property (o_bvalid && o_bresp == 2'h2);
endmodule : fqs_host_assertions

// ==== test/fqs_flash_model.sv ====
`timescale 1ns/1ps
// Behavioural flash device: command decoder, identifier, query, status, erase
module fqs_flash_model #(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART = 8'h6b, // Arbitrary value
  parameter logic [7:0] C_ER = 8'h21,
  parameter logic [7:0] C_CF = 8'h3c,
  parameter logic [7:0] C_RS = 8'h71,
  parameter logic [7:0] C_CL = 8'h51,
  parameter logic [7:0] C_ID = 8'h91,
  parameter logic [7:0] C_BF = 8'he9,
  parameter int ERASE_NS = 600
) (
  input wire fqs_pkg::fqs_pins_t i_pins,
  output logic [15:0] o_dq
);
  logic [1:0] mode = 2'd0; // 0 array, 1 identifier and query, 2 status, 3 buffer
  logic [7:0] sr = 8'h80, snap = 8'h80, buffer_avail_status = 8'h00, d, q;
  logic busy = 1'b0, pend = 1'b0;
  logic [63:0] erased = '0, efail = '0, locked = 64'h2; // Block 1 is locked
  logic [15:0] rd, last = 16'h0000;
  logic [5:0] b;
  wire sel_n = i_pins.chip_select_a_n | i_pins.chip_select_b_n;
  wire drv = !sel_n && !i_pins.oe_n;
  wire [5:0] blk = i_pins.addr[21:16];
  wire [20:0] w = i_pins.addr[21:1]; // Line 0 ignored
  wire wact = !sel_n && !i_pins.we_n; // Write pulse: select and strobe both low
  // Commands latch as the first of select or strobe rises; unknown commands leave the mode, bad confirms go to status
  always @(negedge wact) begin
    d = i_pins.dq_out[7:0];
    b = blk;
    if (pend) begin
      pend = 1'b0;
      mode = 2'd2;
      if (d != C_CF) sr = sr | 8'h30;
      else if (locked[b]) begin sr = sr | 8'h22; efail[b] = 1'b1; end
      else begin
        busy = 1'b1;
        #(ERASE_NS);
        erased[b] = 1'b1;
        efail[b] = 1'b0;
        busy = 1'b0;
      end
    end else begin
      case (d)
        C_ER: pend = 1'b1;
        C_RS: mode = 2'd2;
        C_CL: sr = sr & 8'hc5; // suspend never modelled
        C_ID: mode = 2'd1;
        C_BF: begin mode = 2'd3; buffer_avail_status = 8'h80; end
        8'hff: mode = 2'd0;
        default: ;
      endcase
    end
  end
  // Snapshot on whichever of select and output enable falls last
  always @(posedge drv)
    snap = busy ? 8'h55 : sr;
  // Query table from the fixed base pointer
  always @* begin
    case (w[7:0])
      8'h31: q = 8'h50; 8'h32: q = 8'h52; 8'h33: q = 8'h49; 8'h34: q = 8'h31;
      8'h35: q = 8'h30; 8'h36: q = 8'h0f; 8'h3a: q = 8'h01; 8'h3b: q = 8'h03;
      8'h3d: q = 8'h50; 8'h3e: q = 8'h50; 8'h00: q = MAKER; 8'h01: q = PART;
      default: q = 8'h00;
    endcase
    if (w[14:0] == 15'h2) q = {6'h0, efail[blk], locked[blk]};
    case (mode) // Array, status and query reads served by the current mode
      2'd0: rd = erased[blk] ? 16'hffff : 16'h1234;
      2'd1: rd = {8'h00, q};
      2'd2: rd = {8'h00, snap};
      default: rd = {8'h00, buffer_avail_status};
    endcase
  end
  // Released bus shows the inverse of the last value, never a stale match
  always @(negedge drv) last = rd;
  assign o_dq = drv ? rd : ~last;
endmodule : fqs_flash_model

// ==== test/fqs_host_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
// Drives the controller over its register bus against the flash model
module fqs_host_test;
  localparam logic [31:0] OPA = 32'h5171_3c21; // Clear, status, confirm, erase setup
  localparam logic [31:0] OPB = 32'h0000_e991; // Buffer setup, identifier
  logic i_clk, i_nrst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q, st_q;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] dq;
  fqs_pkg::fqs_pins_t pins;
  int err_count = 0, num_checks = 0;
  logic [7:0] qt [14] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h01,
    8'h03, 8'h00, 8'h50, 8'h50};
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  fqs_host dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_dq(dq),
    .o_flash(pins));
  fqs_flash_model #(.C_ER(OPA[7:0]), .C_CF(OPA[15:8]), .C_RS(OPA[23:16]), .C_CL(OPA[31:24]),
    .C_ID(OPB[7:0]), .C_BF(OPB[15:8])) u_flash (.i_pins(pins), .o_dq(dq));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic hang;
    err_count++;
    $display("wait limit reached at %0t", $time);
    finish_test();
  endtask : hang
  // One write; an edge first so no strobe is set twice in one step
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin rsp = bresp; bready <= 1'b0; break; end
    end
    if (n == 50) hang();
  endtask : axw
  task automatic axr(input logic [4:0] a);
    int n;
    @(posedge i_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin rd_q = rdata; rsp = rresp; rready <= 1'b0; break; end
    end
    if (n == 50) hang();
  endtask : axr
  // Starts an operation, waits for done, keeps status and the read data
  task automatic run(input fqs_pkg::fqs_op_t op, input logic [21:0] adr);
    int n;
    axw(fqs_pkg::OFS_ADDR, {10'h0, adr});
    axw(fqs_pkg::OFS_CTRL, {28'h0, op, 1'b1});
    for (n = 0; n < 300; n++) begin
      axr(fqs_pkg::OFS_STAT);
      if (rd_q[1] === 1'b1) break;
    end
    if (n == 300) hang();
    st_q = rd_q;
    axw(fqs_pkg::OFS_STAT, 32'h6);
    axr(fqs_pkg::OFS_RDATA);
  endtask : run
  task automatic t_regs;
    axr(fqs_pkg::OFS_OPC_A);
    `CHK(rd_q, fqs_pkg::OPC_RST)
    axw(fqs_pkg::OFS_OPC_A, OPA);
    axw(fqs_pkg::OFS_OPC_B, OPB);
    axr(fqs_pkg::OFS_OPC_B);
    `CHK(rd_q, OPB)
    axr(5'h1c);
    `CHK(rsp, 2'h2)
    axw(5'h1c, 32'h1);
    `CHK(rsp, 2'h2)
    $display("registers done");
  endtask : t_regs
  task automatic t_ident;
    for (int i = 0; i < 14; i++) begin
      run(fqs_pkg::OP_ID_READ, 22'h31 + 22'(i));
      `CHK(rd_q[7:0], qt[i])
    end
    run(fqs_pkg::OP_ID_READ, 22'h1);
    `CHK(rd_q[7:0], u_flash.PART)
    run(fqs_pkg::OP_ID_READ, 22'h00_8002);
    `CHK(rd_q[7:0], 8'h01)
    run(fqs_pkg::OP_READ, 22'h0);
    `CHK(rd_q[7:0], u_flash.MAKER)
    $display("identifier done");
  endtask : t_ident
  task automatic t_erase;
    run(fqs_pkg::OP_ERASE, 22'h02_0000);
    `CHK(st_q[5:2], 4'h0)
    `CHK(rd_q[7], 1'b1)
    axw(fqs_pkg::OFS_WDATA, 32'hff);
    run(fqs_pkg::OP_WRITE, 22'h02_0000);
    run(fqs_pkg::OP_READ, 22'h02_0006);
    `CHK(rd_q[15:0], 16'hffff)
    run(fqs_pkg::OP_READ, 22'h03_0000);
    `CHK(rd_q[15:0], 16'h1234)
    $display("erase done");
  endtask : t_erase
  task automatic t_fail;
    run(fqs_pkg::OP_ERASE, 22'h01_0000);
    `CHK(st_q[5:2], 4'b1001)
    run(fqs_pkg::OP_ID_READ, 22'h00_8002);
    `CHK(rd_q[7:0], 8'h03)
    run(fqs_pkg::OP_RD_STATUS, 22'h0);
    `CHK(rd_q[7:0], 8'ha2)
    run(fqs_pkg::OP_READ, 22'h03_0000);
    `CHK(rd_q[15:0], 16'h00a2)
    axw(fqs_pkg::OFS_OPC_A, {OPA[31:16], 8'h77, OPA[7:0]});
    run(fqs_pkg::OP_ERASE, 22'h03_0000);
    `CHK(st_q[5:2], 4'b1101)
    axw(fqs_pkg::OFS_OPC_A, OPA);
    run(fqs_pkg::OP_CLR_STATUS, 22'h0);
    run(fqs_pkg::OP_RD_STATUS, 22'h0);
    `CHK(rd_q[7:0], 8'h80)
    run(fqs_pkg::OP_BUF_STATUS, 22'h03_0000);
    `CHK(rd_q[7:0], 8'h80)
    $display("failures done");
  endtask : t_fail
  initial begin
    i_nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 5'h00; araddr = 5'h00; wdata = 32'h0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_regs();
    t_ident();
    t_erase();
    t_fail();
    finish_test();
  end
endmodule : fqs_host_test
bind fqs_host fqs_host_assertions u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .o_flash(o_flash));
